//--- logic/sbg_tx.sv
`timescale 1ns/1ps
// Operation
// RQ1: Set-then-clear send-break emits exactly one break.
// RQ2: Break lasts 10 or 11 bits, never doubled.
// RQ3: Breaks repeat while send-break stays set.
// RQ4: Enable toggle queues idle frame ahead of others.
// RQ5: Break right after idle has nominal length.
// RQ6: Software toggles enable then send-break, interrupts off.
// RQ7: Break low whole length, then stop-bit high.
module sbg_tx (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic send_break_bit_in,
   input wire logic transmitter_enable_bit_in,
   input wire logic word_long_in,
   input wire logic [15:0] baud_div_in,
   input wire logic data_valid_in,
   input wire logic [8:0] data_in,
   output logic data_ready_out,
   output logic tdo_out,
   output logic busy_out
);
   // ****************************************************************
   // Request capture
   // ****************************************************************
   typedef enum logic [1:0] {
      SBG_ST_IDLE,
      SBG_ST_SHIFT,
      SBG_ST_STOP
   } sbg_state_type;
   sbg_buf_if bus ();
   sbg_buf u_buf (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .port(bus.buffer)
   );
   logic brk_s2, te_s2, brk_d, te_d;
   logic brk_pend, next_brk_pend;
   logic idle_pend, next_idle_pend;
   logic break_end;
   // ****************************************************************
   // Control input synchronisers
   // ****************************************************************
   // Both controls come from another domain, so each bit passes two flops before its edge detector.
   logic [1:0] ctl_raw;
   logic [1:0] ctl_s1;
   logic [1:0] ctl_s2;
   logic [1:0] ctl_d;
   assign ctl_raw = {transmitter_enable_bit_in, send_break_bit_in};
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctl_s1 <= 2'h0;
         ctl_s2 <= 2'h0;
         ctl_d <= 2'h0;
      end else begin
         ctl_s1 <= ctl_raw;
         ctl_s2 <= ctl_s1;
         ctl_d <= ctl_s2;
      end
   end
   assign brk_s2 = ctl_s2[0];
   assign te_s2 = ctl_s2[1];
   assign brk_d = ctl_d[0];
   assign te_d = ctl_d[1];
   // ****************************************************************
   // Request queueing
   // ****************************************************************
   // Each request enters the queue only once, so a break can never be doubled.
   always_comb begin
      next_brk_pend = brk_pend;
      next_idle_pend = idle_pend;
      bus.in_valid = 1'b0;
      bus.in_item = '0;
      data_ready_out = 1'b0;
      if (idle_pend) begin
         bus.in_valid = 1'b1;
         bus.in_item.kind = sbg_pkg::SBG_REQ_IDLE; // [RQ4]
         if (bus.in_ready) begin
            next_idle_pend = 1'b0;
         end
      end else if (brk_pend) begin
         bus.in_valid = 1'b1;
         bus.in_item.kind = sbg_pkg::SBG_REQ_BREAK; // [RQ5]
         if (bus.in_ready) begin
            next_brk_pend = 1'b0; // [RQ1]
         end
      end else begin
         bus.in_valid = data_valid_in && te_s2;
         bus.in_item.kind = sbg_pkg::SBG_REQ_DATA;
         bus.in_item.data = data_in;
         data_ready_out = bus.in_ready && te_s2;
      end
      // New requests come after the accept above, so a request in the cycle of an accept is kept.
      if (te_s2 && !te_d) begin
         next_idle_pend = 1'b1; // [RQ4]
      end
      if (brk_s2 && !brk_d) begin
         next_brk_pend = 1'b1; // [RQ1]
      end
      // Re-arming at the end of the low part, not at the accept, keeps a short pulse to one break.
      if (break_end && brk_s2) begin
         next_brk_pend = 1'b1; // [RQ3]
      end
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         brk_pend <= 1'b0;
         idle_pend <= 1'b0;
      end else begin
         brk_pend <= next_brk_pend;
         idle_pend <= next_idle_pend;
      end
   end
   // ****************************************************************
   // Line sequencer
   // ****************************************************************
   sbg_state_type state, next_state;
   logic [15:0] tick, next_tick;
   logic [3:0] bits, next_bits;
   logic [3:0] frame_len, next_frame_len;
   logic [10:0] shreg, next_shreg;
   logic tdo, next_tdo;
   sbg_pkg::sbg_req_type kind, next_kind;
   logic bit_end;
   logic [3:0] nominal;
   assign bit_end = (tick == 16'h0000);
   assign nominal = word_long_in ? sbg_pkg::BREAK_BITS_LONG : sbg_pkg::BREAK_BITS_SHORT;
   assign break_end = (state == SBG_ST_SHIFT) && bit_end && (bits + 4'h1 == frame_len) &&
                      (kind == sbg_pkg::SBG_REQ_BREAK);
   // ****************************************************************
   // Bit timer
   // ****************************************************************
   // The timer runs free, so a frame starts only on a bit boundary and its first bit has full length.
   always_comb begin
      next_tick = tick - 16'h0001;
      if (bit_end) begin
         next_tick = baud_div_in;
      end
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tick <= sbg_pkg::BAUD_DIV_RESET;
      end else begin
         tick <= next_tick;
      end
   end
   // ****************************************************************
   // Frame sequencer
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_kind = kind;
      next_bits = bits;
      next_frame_len = frame_len;
      next_shreg = shreg;
      next_tdo = tdo;
      bus.out_ready = 1'b0;
      case (state)
         SBG_ST_IDLE: begin
            next_tdo = 1'b1;
            if (bus.out_valid && bit_end) begin
               bus.out_ready = 1'b1;
               next_state = SBG_ST_SHIFT;
               next_bits = 4'h0;
               next_frame_len = nominal; // [RQ2]
               next_kind = bus.out_item.kind;
               case (bus.out_item.kind)
                  sbg_pkg::SBG_REQ_IDLE: next_shreg = '1;
                  sbg_pkg::SBG_REQ_BREAK: next_shreg = '0; // [RQ7]
                  default: begin
                     next_shreg = word_long_in ? {1'b1, bus.out_item.data, 1'b0}
                                               : {2'b11, bus.out_item.data[7:0], 1'b0};
                  end
               endcase
               next_tdo = (bus.out_item.kind == sbg_pkg::SBG_REQ_IDLE) ? 1'b1 :
                          (bus.out_item.kind == sbg_pkg::SBG_REQ_BREAK) ? 1'b0 : 1'b0;
            end
         end
         SBG_ST_SHIFT: begin
            if (bit_end) begin
               next_bits = bits + 4'h1;
               next_shreg = {1'b1, shreg[10:1]};
               if (bits + 4'h1 == frame_len) begin
                  next_state = SBG_ST_STOP; // [RQ2]
                  next_bits = 4'h0;
                  next_tdo = 1'b1; // [RQ7]
               end else begin
                  next_tdo = next_shreg[0];
               end
            end
         end
         SBG_ST_STOP: begin
            if (bit_end) begin
               next_bits = bits + 4'h1;
               if (bits + 4'h1 == sbg_pkg::STOP_BITS) begin
                  next_state = SBG_ST_IDLE; // [RQ7]
               end
            end
         end
         default: next_state = SBG_ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= SBG_ST_IDLE;
         kind <= sbg_pkg::SBG_REQ_IDLE;
         bits <= 4'h0;
         frame_len <= sbg_pkg::BREAK_BITS_SHORT;
         shreg <= '1;
         tdo <= 1'b1;
      end else begin
         state <= next_state;
         kind <= next_kind;
         bits <= next_bits;
         frame_len <= next_frame_len;
         shreg <= next_shreg;
         tdo <= next_tdo;
      end
   end
   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign tdo_out = tdo;
   assign busy_out = (state != SBG_ST_IDLE) || bus.out_valid || idle_pend || brk_pend;
endmodule

//--- pkg/sbg_pkg.sv
package sbg_pkg;
   // ****************************************************************
   // Frame lengths in bit periods, buffer depth and reset baud divider
   // ****************************************************************
   localparam logic [3:0] BREAK_BITS_SHORT = 4'ha;
   localparam logic [3:0] BREAK_BITS_LONG = 4'hb;
   localparam logic [3:0] STOP_BITS = 4'h1;
   localparam int BUF_DEPTH = 2;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h0008;
   typedef enum logic [1:0] {
      SBG_REQ_IDLE,
      SBG_REQ_BREAK,
      SBG_REQ_DATA
   } sbg_req_type;
   typedef struct packed {
      sbg_req_type kind;
      logic [8:0] data;
   } sbg_item_type;
endpackage

//--- pkg/sbg_buf_if.sv
`timescale 1ns/1ps
interface sbg_buf_if;
   logic in_valid;
   logic in_ready;
   sbg_pkg::sbg_item_type in_item;
   logic out_valid;
   logic out_ready;
   sbg_pkg::sbg_item_type out_item;
   modport buffer (input in_valid, output in_ready, input in_item, output out_valid, input out_ready,
      output out_item);
   modport user (output in_valid, input in_ready, output in_item, input out_valid, output out_ready,
      input out_item);
endinterface

//--- logic/sbg_buf.sv
`timescale 1ns/1ps
module sbg_buf (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   sbg_buf_if.buffer port
);
   // ****************************************************************
   // Two-entry request buffer
   // ****************************************************************
   sbg_pkg::sbg_item_type mem [sbg_pkg::BUF_DEPTH];
   sbg_pkg::sbg_item_type next_mem [sbg_pkg::BUF_DEPTH];
   logic [1:0] count;
   logic [1:0] next_count;
   logic push;
   logic pop;
   assign port.in_ready = (count != 2'h2);
   assign port.out_valid = (count != 2'h0);
   assign port.out_item = mem[0];
   assign push = port.in_valid && port.in_ready;
   assign pop = port.out_valid && port.out_ready;
   always_comb begin
      next_mem = mem;
      next_count = count;
      if (pop) begin
         next_mem[0] = mem[1];
      end
      if (push) begin
         if (count == 2'h0 || (count == 2'h1 && pop)) begin
            next_mem[0] = port.in_item;
         end else if (pop) begin
            next_mem[0] = mem[1];
            next_mem[1] = port.in_item;
         end else begin
            next_mem[1] = port.in_item;
         end
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         count <= next_count;
         mem <= next_mem;
      end
   end
endmodule

//--- testbench/sbg_tx_props.sv
`timescale 1ns/1ps
module sbg_tx_props (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic send_break_bit_in,
   input wire logic transmitter_enable_bit_in,
   input wire logic word_long_in,
   input wire logic [15:0] baud_div_in,
   input wire logic tdo_out,
   input wire logic busy_out
);
   // ********
   // Run counters
   // ********
   logic [31:0] lo, hi, bp, len;
   assign bp = {16'h0000, baud_div_in} + 32'h1;
   assign len = bp * (word_long_in ? 32'hb : 32'ha);
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lo <= 32'h0;
         hi <= 32'h0;
      end else begin
         lo <= tdo_out ? 32'h0 : lo + 32'h1;
         hi <= tdo_out ? hi + 32'h1 : 32'h0;
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   property p_len; lo <= len; endproperty
   a_len: assert property (p_len) else $error("low run too long");
   property p_exact; $rose(tdo_out) && lo > len - bp |-> lo == len; endproperty
   a_exact: assert property (p_exact) else $error("break length off");
   property p_stop; $fell(tdo_out) |-> hi >= bp; endproperty
   a_stop: assert property (p_stop) else $error("stop bit short");
   property p_busy; !tdo_out |-> busy_out; endproperty
   a_busy: assert property (p_busy) else $error("low while not busy");
   property p_rep; send_break_bit_in [*8] |-> ##[0:80] !tdo_out; endproperty
   a_rep: assert property (p_rep) else $error("no repeated break");
   property p_idle; $rose(transmitter_enable_bit_in) |-> ##[1:8] busy_out; endproperty
   a_idle: assert property (p_idle) else $error("idle not queued");
endmodule
bind sbg_tx sbg_tx_props u_props (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
   .send_break_bit_in(send_break_bit_in), .transmitter_enable_bit_in(transmitter_enable_bit_in),
   .word_long_in(word_long_in), .baud_div_in(baud_div_in), .tdo_out(tdo_out), .busy_out(busy_out));

//--- testbench/sbg_rx_model.sv
`timescale 1ns/1ps
module sbg_rx_model (
   input wire logic clk_sys_in,
   input wire logic line_in,
   input wire logic word_long_in,
   input wire logic [15:0] baud_div_in,
   output int n_breaks_out,
   output int last_low_out
);
   // ********
   // A low run of a full frame or more counts as a break, so a doubled one is seen too.
   // ********
   int run = 0;
   initial begin
      n_breaks_out = 0;
      last_low_out = 0;
   end
   always @(posedge clk_sys_in) begin
      if (!line_in) begin
         run = run + 1;
      end else if (run > 0) begin
         last_low_out = run;
         if (run >= (int'(baud_div_in) + 1) * (word_long_in ? 11 : 10)) n_breaks_out++;
         run = 0;
      end
   end
endmodule

//--- testbench/sbg_tx_tb_top.sv
`timescale 1ns/1ps
module sbg_tx_tb_top;
   logic clk_sys_in = 0, nrst_in = 0, send_break_bit = 0, en = 1, wl = 0, dv = 0, rdy, tdo, busy;
   int miscompares = 0, n_checks = 0, nb, ll, b, k;
   always #2 clk_sys_in = ~clk_sys_in;
   sbg_tx dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .send_break_bit_in(send_break_bit),
      .transmitter_enable_bit_in(en), .word_long_in(wl), .baud_div_in(16'h0001), .data_valid_in(dv),
      .data_in(9'h000), .data_ready_out(rdy), .tdo_out(tdo), .busy_out(busy));
   sbg_rx_model rx (.clk_sys_in(clk_sys_in), .line_in(tdo), .word_long_in(wl), .baud_div_in(16'h0001),
      .n_breaks_out(nb), .last_low_out(ll));
   task chk(input logic [31:0] seen, exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task print_verdict;
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task settle;
      tick(8);
      k = 0;
      while (busy !== 1'b0 && k < 400) begin
         tick(1);
         k++;
      end
      chk(k < 400, 1, "busy end");
      tick(4);
   endtask
   task t_reset;
      chk(tdo, 1, "reset line");
      chk(busy, 0, "reset busy");
      chk(rdy, 0, "reset ready");
   endtask
   task t_one(input logic w);
      wl = w;
      b = nb;
      send_break_bit = 1;
      tick(2);
      send_break_bit = 0;
      settle;
      chk(nb - b, 1, "break count");
      chk(ll, w ? 22 : 20, "break low");
   endtask
   task t_rep;
      wl = 0;
      b = nb;
      send_break_bit = 1;
      tick(100);
      send_break_bit = 0;
      settle;
      chk(nb - b >= 3, 1, "repeat breaks");
      chk(ll, 20, "repeat low");
   endtask
   task t_idle;
      wl = 1;
      en = 0;
      tick(8);
      en = 1;
      k = 0;
      while (tdo !== 1'b0 && k < 300) begin
         if (k == 2) send_break_bit = 1;
         if (k == 4) send_break_bit = 0;
         tick(1);
         k++;
      end
      chk(k >= 22, 1, "idle first");
      settle;
      chk(ll, 22, "break after idle");
   endtask
   task t_data;
      wl = 0;
      b = nb;
      dv = 1;
      k = 0;
      while (rdy !== 1'b1 && k < 100) begin
         tick(1);
         k++;
      end
      tick(1);
      dv = 0;
      chk(k < 100, 1, "data taken");
      settle;
      chk(ll, 18, "data low");
      chk(nb - b, 0, "no break");
   endtask
   initial begin
      tick(16);
      t_reset;
      nrst_in = 1;
      tick(4);
      t_one(0);
      t_one(1);
      t_rep;
      t_idle;
      t_data;
      print_verdict;
   end
   initial begin
      #40000;
      miscompares++;
      print_verdict;
   end
endmodule
